//--- dsp_pkg.sv
`default_nettype none
package dsp_pkg;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD  = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;

  // clock source dividers and oversampling
  localparam int DIV_93      = 93;
  localparam int DIV_372     = 372;
  localparam int DIV_186     = 186;
  localparam int OVERSAMPLE  = 16;
  localparam logic [3:0] OVS_HALF = 4'h8;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [3:0] SYNC_LAST = 4'h7;
  localparam logic [3:0] DATA7    = 4'h7;
  localparam logic [3:0] DATA8    = 4'h8;
  localparam logic [3:0] FRAME_OVERHEAD = 4'h2;

  // command (write) and status (read) bit positions of REG_CMD
  localparam int CMD_TX_TRIG   = 0;
  localparam int CMD_RX_TRIG   = 1;
  localparam int CMD_CLR_OVR   = 2;
  localparam int CMD_CLR_PAR   = 3;
  localparam int CMD_CLR_FRM   = 4;
  localparam int ST_RX_FULL    = 5;

  typedef enum logic [1:0] {
    MODE_SYNC_MASTER = 2'h0,
    MODE_SYNC_SLAVE  = 2'h1,
    MODE_ASYNC7      = 2'h2,
    MODE_ASYNC8      = 2'h3
  } dsp_mode_t;

  typedef enum logic [1:0] {
    SRC_DIV186 = 2'h0,
    SRC_DIV372 = 2'h1,
    SRC_DIV93  = 2'h2,
    SRC_TIMER  = 2'h3
  } dsp_src_t;

  typedef struct packed {
    logic      rxCompleteIe;
    logic      txCompleteIe;
    logic      receive_enable_bit;
    logic      transmit_enable_bit;
    logic      parityOdd;
    logic      parityEn;
    dsp_src_t  clkSrc;
    dsp_mode_t mode;
  } dsp_ctrl_t;

  localparam dsp_ctrl_t CTRL_RESET = '{rxCompleteIe: 1'b0, txCompleteIe: 1'b0, receive_enable_bit: 1'b0, transmit_enable_bit: 1'b0,
                                      parityOdd: 1'b0, parityEn: 1'b0, clkSrc: SRC_DIV186,
                                      mode: MODE_SYNC_MASTER};

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } dsp_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dsp_wb_rsp_t;

  typedef struct packed {
    logic serialDataOut;
    logic serialClockOut;
    logic serialClockOe;
    logic slaveReadyOutputN;
    logic slaveReadyOe;
  } dsp_pins_t;

  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} dsp_txst_t;
  typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} dsp_rxst_t;

endpackage : dsp_pkg
`default_nettype wire

//--- dsp_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module dsp_sync2 #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dsp_sync_st_t;

  dsp_sync_st_t s_q;
  dsp_sync_st_t s_d;

  if (W < 1) begin : g_chk
    $error("dsp_sync2: W must be at least 1");
  end

  always_comb begin
    s_d        = s_q;
    s_d.meta   = asyncIn;
    s_d.stable = s_q.meta;
    // idle lines rest high
    if (sys_rst) begin
      s_d = '1;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign syncOut = s_q.stable;
endmodule : dsp_sync2
`default_nettype wire

//--- dsp_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none
module dsp_baud_gen #(
  parameter int OVERSAMPLE = dsp_pkg::OVERSAMPLE
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire dsp_pkg::dsp_src_t clkSrc,
  input  wire logic             fastOscTick,
  input  wire logic             timerUnderflow,
  output var  logic             srcTick,
  output var  logic             shiftTick
);
  localparam int OW = $clog2(OVERSAMPLE);

  typedef struct packed {
    logic [8:0]    divCnt;
    logic          timerHalf;
    logic [OW-1:0] ovsCnt;
    logic          srcTick;
    logic          shiftTick;
  } dsp_baud_st_t;

  dsp_baud_st_t s_q;
  dsp_baud_st_t s_d;
  logic [8:0]   divLimit;
  logic         srcPulse;

  if (OVERSAMPLE < 2 || OVERSAMPLE > 16 || (1 << OW) != OVERSAMPLE) begin : g_chk
    $error("dsp_baud_gen: OVERSAMPLE must be a power of two from 2 to 16");
  end

  always_comb begin
    s_d           = s_q;
    s_d.srcTick   = 1'b0;
    s_d.shiftTick = 1'b0;
    srcPulse      = 1'b0;
    case (clkSrc)
      dsp_pkg::SRC_DIV93:  divLimit = 9'(dsp_pkg::DIV_93);
      dsp_pkg::SRC_DIV372: divLimit = 9'(dsp_pkg::DIV_372);
      default:             divLimit = 9'(dsp_pkg::DIV_186);
    endcase
    if (clkSrc == dsp_pkg::SRC_TIMER) begin
      // every second underflow gives one source tick
      if (timerUnderflow) begin
        s_d.timerHalf = !s_q.timerHalf;
        srcPulse      = s_q.timerHalf;
      end
    end else if (fastOscTick) begin
      if (s_q.divCnt >= divLimit - 9'h1) begin
        s_d.divCnt = '0;
        srcPulse   = 1'b1;
      end else begin
        s_d.divCnt = s_q.divCnt + 9'h1;
      end
    end
    if (srcPulse) begin
      s_d.srcTick = 1'b1;
      s_d.ovsCnt  = s_q.ovsCnt + OW'(1);
      // further divide by the oversample factor for the bit clock
      if (s_q.ovsCnt == OW'(OVERSAMPLE - 1)) begin
        s_d.shiftTick = 1'b1;
      end
    end
    if (sys_rst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign srcTick   = s_q.srcTick;
  assign shiftTick = s_q.shiftTick;
endmodule : dsp_baud_gen
`default_nettype wire

//--- dsp_serial_port.sv
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - seven- or eight-bit async with optional parity, no clock pins
// - source field picks timer or fixed oscillator divisors
// - slave uses external shift clock undivided
// - timer source is half of underflow rate
// - reset selects the divide-by-186 source
// - source divided by sixteen for shift clock
// - separate transmit and receive shift registers
// - received byte copied to separate readable buffer
// - transmit enable gates transmit clock and pin
// - transmit trigger starts shifting out loaded data
// - transmit completion raises enabled interrupt event
// - transmit trigger reads one while transmitting
// - receive enable gates receive clock and pin
// - sync receive trigger starts; slave drives ready low
// - async receive trigger empties buffer; overrun otherwise
// - receive trigger reads one while receiving
// - sync transfers eight bits, least significant first
// - master drives divided shift clock on pin
// - sync modes are half duplex only
// - mode field encodings, sync master on reset
// - sync data changes on fall, sampled on rise
// - async frame one start, one stop, LSB first
module dsp_serial_port (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire dsp_pkg::dsp_wb_req_t wbReq,
  output var  dsp_pkg::dsp_wb_rsp_t wbRsp,
  input  wire logic                 fastOscTick,
  input  wire logic                 timerUnderflow,
  input  wire logic                 serialDataIn,
  input  wire logic                 serialClockIn,
  output var  dsp_pkg::dsp_pins_t   pinOut,
  output var  logic                 txCompleteIrq,
  output var  logic                 rxCompleteIrq
);
  typedef struct packed {
    dsp_pkg::dsp_ctrl_t ctrl;
    logic               ack;
    logic [31:0]        rdata;
    dsp_pkg::dsp_txst_t txSt;
    logic [7:0]         txData;
    logic [10:0]        txShift;
    logic [3:0]         txCnt;
    logic               serial_data_out;
    dsp_pkg::dsp_rxst_t rxSt;
    logic [7:0]         rxShift;
    logic               rxPar;
    logic [3:0]         rxCnt;
    logic [3:0]         rxPhase;
    logic [7:0]         rxBuf;
    logic               bufEmpty;
    logic               overrun;
    logic               parityErr;
    logic               frameErr;
    logic [3:0]         sclkPhase;
    logic               sclk;
    logic               sclkPrev;
    logic               rxdPrev;
    logic               srdyN;
    logic               txIrq;
    logic               rxIrq;
  } dsp_state_t;

  dsp_state_t  s_q;
  dsp_state_t  s_d;
  logic [1:0]  pinSync;
  logic        rxdSync;
  logic        sclkSync;
  logic        srcTick;
  logic        shiftTick;
  logic        isSync;
  logic        isMaster;
  logic        isSlave;
  logic        syncBusy;
  logic        fallEdge;
  logic        riseEdge;
  logic        busReq;
  logic        txTrigWr;
  logic        rxTrigWr;
  logic        txGo;
  logic        rxGo;
  logic        rxDone;
  logic [3:0]  dataBits;
  logic [3:0]  frameLen;
  logic [10:0] frame;
  logic [7:0]  txBits;
  logic [9:0]  ctrlBits;
  logic [31:0] statusWord;

  dsp_sync2 #(
    .W (2)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({serialClockIn, serialDataIn}),
    .syncOut (pinSync)
  );

  dsp_baud_gen #(
    .OVERSAMPLE (dsp_pkg::OVERSAMPLE)
  ) u_baud (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .clkSrc         (s_q.ctrl.clkSrc),
    .fastOscTick    (fastOscTick),
    .timerUnderflow (timerUnderflow),
    .srcTick        (srcTick),
    .shiftTick      (shiftTick)
  );

  assign rxdSync  = pinSync[0];
  assign sclkSync = pinSync[1];

  always_comb begin
    s_d      = s_q;
    s_d.ack  = 1'b0;
    s_d.txIrq = 1'b0;
    s_d.rxIrq = 1'b0;
    txGo     = 1'b0;
    rxGo     = 1'b0;
    rxDone   = 1'b0;
    txTrigWr = 1'b0;
    rxTrigWr = 1'b0;
    isSync   = (s_q.ctrl.mode == dsp_pkg::MODE_SYNC_MASTER) || (s_q.ctrl.mode == dsp_pkg::MODE_SYNC_SLAVE);
    isMaster = (s_q.ctrl.mode == dsp_pkg::MODE_SYNC_MASTER);
    isSlave  = (s_q.ctrl.mode == dsp_pkg::MODE_SYNC_SLAVE);
    syncBusy = (s_q.txSt == dsp_pkg::TX_SYNC) || (s_q.rxSt == dsp_pkg::RX_SYNC);
    // slave edges come from the pin, master edges from the divided clock
    if (isMaster) begin
      fallEdge = srcTick && syncBusy && (s_q.sclkPhase == 4'h0);
      riseEdge = srcTick && syncBusy && (s_q.sclkPhase == dsp_pkg::OVS_HALF);
    end else begin
      fallEdge = isSlave && s_q.sclkPrev && !sclkSync;
      riseEdge = isSlave && !s_q.sclkPrev && sclkSync;
    end
    dataBits = (s_q.ctrl.mode == dsp_pkg::MODE_ASYNC7) ? dsp_pkg::DATA7 : dsp_pkg::DATA8;
    frameLen = dataBits + dsp_pkg::FRAME_OVERHEAD + {3'h0, s_q.ctrl.parityEn};
    txBits   = (s_q.ctrl.mode == dsp_pkg::MODE_ASYNC7) ? {1'b0, s_q.txData[6:0]} : s_q.txData;
    // start, data LSB first, optional parity, stop
    frame    = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < dataBits) begin
        frame[i + 1] = txBits[i];
      end
    end
    if (s_q.ctrl.parityEn) begin
      frame[dataBits + 4'h1] = (^txBits) ^ s_q.ctrl.parityOdd;
    end
    ctrlBits   = s_q.ctrl;
    statusWord = '0;
    statusWord[dsp_pkg::CMD_TX_TRIG] = (s_q.txSt != dsp_pkg::TX_IDLE);
    statusWord[dsp_pkg::CMD_RX_TRIG] = (s_q.rxSt != dsp_pkg::RX_IDLE);
    statusWord[dsp_pkg::CMD_CLR_OVR] = s_q.overrun;
    statusWord[dsp_pkg::CMD_CLR_PAR] = s_q.parityErr;
    statusWord[dsp_pkg::CMD_CLR_FRM] = s_q.frameErr;
    statusWord[dsp_pkg::ST_RX_FULL]  = !s_q.bufEmpty;

    // register bus: one access per request, ack the next cycle
    busReq = wbReq.cyc && wbReq.stb && !s_q.ack;
    if (busReq) begin
      s_d.ack   = 1'b1;
      s_d.rdata = '0;
      case (wbReq.adr)
        dsp_pkg::REG_CTRL: begin
          s_d.rdata = {22'h0, ctrlBits};
          if (wbReq.we) begin
            if (wbReq.sel[0]) begin
              ctrlBits[7:0] = wbReq.dat[7:0];
            end
            if (wbReq.sel[1]) begin
              ctrlBits[9:8] = wbReq.dat[9:8];
            end
            s_d.ctrl = dsp_pkg::dsp_ctrl_t'(ctrlBits);
          end
        end
        dsp_pkg::REG_CMD: begin
          s_d.rdata = statusWord;
          if (wbReq.we && wbReq.sel[0]) begin
            txTrigWr = wbReq.dat[dsp_pkg::CMD_TX_TRIG];
            rxTrigWr = wbReq.dat[dsp_pkg::CMD_RX_TRIG];
            if (wbReq.dat[dsp_pkg::CMD_CLR_OVR]) begin
              s_d.overrun = 1'b0;
            end
            if (wbReq.dat[dsp_pkg::CMD_CLR_PAR]) begin
              s_d.parityErr = 1'b0;
            end
            if (wbReq.dat[dsp_pkg::CMD_CLR_FRM]) begin
              s_d.frameErr = 1'b0;
            end
          end
        end
        dsp_pkg::REG_DATA: begin
          s_d.rdata = {24'h0, s_q.rxBuf};
          if (wbReq.we && wbReq.sel[0]) begin
            s_d.txData = wbReq.dat[7:0];
          end
        end
        default: s_d.rdata = '0;
      endcase
    end

    // triggers; in sync modes only one direction may own the clock line
    if (txTrigWr && s_q.ctrl.transmit_enable_bit && (s_q.txSt == dsp_pkg::TX_IDLE)) begin
      if (!isSync) begin
        txGo        = 1'b1;
        s_d.txSt    = dsp_pkg::TX_ASYNC;
        s_d.txShift = frame;
        s_d.txCnt   = '0;
      end else if (s_q.rxSt == dsp_pkg::RX_IDLE) begin
        txGo        = 1'b1;
        s_d.txSt    = dsp_pkg::TX_SYNC;
        s_d.txShift = {3'h7, s_q.txData};
        s_d.txCnt   = '0;
      end
    end
    if (rxTrigWr) begin
      if (!isSync) begin
        s_d.bufEmpty = 1'b1;
      end else if (s_q.ctrl.receive_enable_bit && (s_q.rxSt == dsp_pkg::RX_IDLE) && (s_q.txSt == dsp_pkg::TX_IDLE) && !txGo) begin
        rxGo        = 1'b1;
        s_d.rxSt    = dsp_pkg::RX_SYNC;
        s_d.rxCnt   = '0;
        s_d.rxShift = '0;
      end
    end
    if (isSync && (txGo || rxGo)) begin
      s_d.sclkPhase = '0;
      if (isSlave) begin
        s_d.srdyN = 1'b0;
      end
    end
    if (isMaster && syncBusy && srcTick) begin
      s_d.sclkPhase = s_q.sclkPhase + 4'h1;
      if (fallEdge) begin
        s_d.sclk = 1'b0;
      end
      if (riseEdge) begin
        s_d.sclk = 1'b1;
      end
    end
    // ready returns high on the first incoming falling edge
    if (isSlave && fallEdge) begin
      s_d.srdyN = 1'b1;
    end
    s_d.sclkPrev = sclkSync;
    s_d.rxdPrev  = rxdSync;

    // transmitter, own shift register so async runs full duplex
    case (s_q.txSt)
      dsp_pkg::TX_ASYNC: begin
        // bits change on shift ticks only, so the start bit is full length
        if (shiftTick) begin
          if (s_q.txCnt == frameLen) begin
            s_d.txSt  = dsp_pkg::TX_IDLE;
            s_d.txIrq = s_q.ctrl.txCompleteIe;
          end else begin
            s_d.serial_data_out    = s_q.txShift[0];
            s_d.txShift = {1'b1, s_q.txShift[10:1]};
            s_d.txCnt   = s_q.txCnt + 4'h1;
          end
        end
      end
      dsp_pkg::TX_SYNC: begin
        if (fallEdge) begin
          s_d.serial_data_out    = s_q.txShift[0];
          s_d.txShift = {1'b1, s_q.txShift[10:1]};
        end
        if (riseEdge) begin
          s_d.txCnt = s_q.txCnt + 4'h1;
          if (s_q.txCnt == dsp_pkg::SYNC_LAST) begin
            s_d.txSt  = dsp_pkg::TX_IDLE;
            s_d.sclk  = 1'b1;
            s_d.txIrq = s_q.ctrl.txCompleteIe;
          end
        end
      end
      default: ;
    endcase

    // receiver
    case (s_q.rxSt)
      dsp_pkg::RX_IDLE: begin
        if (!isSync && s_q.ctrl.receive_enable_bit && s_q.rxdPrev && !rxdSync) begin
          s_d.rxSt    = dsp_pkg::RX_ASYNC;
          s_d.rxPhase = '0;
          s_d.rxCnt   = '0;
          s_d.rxShift = '0;
        end
      end
      dsp_pkg::RX_ASYNC: begin
        if (srcTick) begin
          s_d.rxPhase = s_q.rxPhase + 4'h1;
          if (s_q.rxPhase == dsp_pkg::OVS_MID) begin
            s_d.rxCnt = s_q.rxCnt + 4'h1;
            if (s_q.rxCnt == 4'h0) begin
              // a start bit that is high at its centre was a glitch
              if (rxdSync) begin
                s_d.rxSt = dsp_pkg::RX_IDLE;
              end
            end else if (s_q.rxCnt <= dataBits) begin
              s_d.rxShift[3'(s_q.rxCnt - 4'h1)] = rxdSync;
            end else if (s_q.ctrl.parityEn && (s_q.rxCnt == dataBits + 4'h1)) begin
              s_d.rxPar = rxdSync;
            end else begin
              rxDone   = 1'b1;
              s_d.rxSt = dsp_pkg::RX_IDLE;
              if (!rxdSync) begin
                s_d.frameErr = 1'b1;
              end
              if (s_q.ctrl.parityEn && ((^s_q.rxShift) ^ s_q.ctrl.parityOdd) != s_q.rxPar) begin
                s_d.parityErr = 1'b1;
              end
              if (!s_q.bufEmpty && !rxTrigWr) begin
                s_d.overrun = 1'b1;
              end
              s_d.rxBuf    = s_q.rxShift;
              s_d.bufEmpty = 1'b0;
              s_d.rxIrq    = s_q.ctrl.rxCompleteIe;
            end
          end
        end
      end
      dsp_pkg::RX_SYNC: begin
        if (riseEdge) begin
          s_d.rxShift[3'(s_q.rxCnt)] = rxdSync;
          s_d.rxCnt = s_q.rxCnt + 4'h1;
          if (s_q.rxCnt == dsp_pkg::SYNC_LAST) begin
            // no overrun check here: the previous byte in rxBuf is simply replaced
            rxDone       = 1'b1;
            s_d.rxSt     = dsp_pkg::RX_IDLE;
            s_d.sclk     = 1'b1;
            s_d.rxBuf    = s_d.rxShift;
            s_d.bufEmpty = 1'b0;
            s_d.rxIrq    = s_q.ctrl.rxCompleteIe;
          end
        end
      end
      default: s_d.rxSt = dsp_pkg::RX_IDLE;
    endcase

    if (sys_rst) begin
      s_d          = '0;
      s_d.ctrl     = dsp_pkg::CTRL_RESET;
      s_d.serial_data_out     = 1'b1;
      s_d.sclk     = 1'b1;
      s_d.sclkPrev = 1'b1;
      s_d.rxdPrev  = 1'b1;
      s_d.srdyN    = 1'b1;
      s_d.bufEmpty = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign wbRsp.ack = s_q.ack;
  assign wbRsp.dat = s_q.rdata;
  assign pinOut.serialDataOut     = s_q.serial_data_out;
  assign pinOut.serialClockOut    = s_q.sclk;
  assign pinOut.serialClockOe     = isMaster && (s_q.ctrl.transmit_enable_bit || s_q.ctrl.receive_enable_bit);
  assign pinOut.slaveReadyOutputN = s_q.srdyN;
  assign pinOut.slaveReadyOe      = isSlave && (s_q.ctrl.transmit_enable_bit || s_q.ctrl.receive_enable_bit);
  assign txCompleteIrq = s_q.txIrq;
  assign rxCompleteIrq = s_q.rxIrq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  reset_default_a: assert property ($fell(sys_rst) |->
    s_q.ctrl.clkSrc == dsp_pkg::SRC_DIV186 && s_q.ctrl.mode == dsp_pkg::MODE_SYNC_MASTER)
    else $error("reset did not select default source and mode");
  tx_start_a: assert property (txGo |=> s_q.txSt != dsp_pkg::TX_IDLE ##0 statusWord[0])
    else $error("accepted transmit trigger did not show busy");
  tx_gate_a: assert property ((txTrigWr && !s_q.ctrl.transmit_enable_bit && s_q.txSt == dsp_pkg::TX_IDLE)
    |=> s_q.txSt == dsp_pkg::TX_IDLE)
    else $error("transmit started while disabled");
  half_duplex_a: assert property (!(s_q.txSt == dsp_pkg::TX_SYNC && s_q.rxSt == dsp_pkg::RX_SYNC))
    else $error("sync transmit and receive ran together");
  ready_low_a: assert property ((isSlave && (txGo || rxGo)) |=> !s_q.srdyN)
    else $error("slave ready not driven low on trigger");
  overrun_set_a: assert property ((rxDone && !isSync && !s_q.bufEmpty && !rxTrigWr) |=> s_q.overrun)
    else $error("overrun not flagged");
  sync_eight_a: assert property ((s_q.txSt == dsp_pkg::TX_SYNC && riseEdge && s_q.txCnt == dsp_pkg::SYNC_LAST)
    |=> s_q.txSt == dsp_pkg::TX_IDLE && s_q.txIrq == s_q.ctrl.txCompleteIe)
    else $error("sync transmit did not end after eight bits");
  slave_clk_a: assert property (!isMaster |-> !pinOut.serialClockOe)
    else $error("clock pin driven outside master mode");
  async_pins_a: assert property (!isSync |-> !pinOut.serialClockOe && !pinOut.slaveReadyOe)
    else $error("clock or ready pin driven in async mode");
  rx_buffer_a: assert property (rxDone |=> !s_q.bufEmpty ##0 s_q.rxBuf == $past(s_d.rxBuf))
    else $error("received byte not moved to buffer");

  tx_async_c: cover property (s_q.txSt == dsp_pkg::TX_ASYNC ##1 s_q.txSt == dsp_pkg::TX_IDLE);
  rx_async_c: cover property (rxDone && !isSync);
  sync_tx_c:  cover property (s_q.txSt == dsp_pkg::TX_SYNC ##1 s_q.txSt == dsp_pkg::TX_IDLE);
  overrun_c:  cover property ($rose(s_q.overrun));
endmodule : dsp_serial_port
`default_nettype wire

//--- dsp_term_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsp_term_model (
  input  wire logic clk,
  input  wire logic lineIn,
  input  wire logic sclkIn,
  output var  logic sclkOut,
  output var  logic lineOut
);
  initial lineOut = 1'b1;
  initial sclkOut = 1'b1;
  // idle high, one start, lsb first, one stop
  task automatic sendAsync(input int bp, input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      lineOut <= fr[i];
      repeat (bp) @(posedge clk);
    end
  endtask : sendAsync
  // centre sampling from the start edge
  task automatic catchAsync(input int bp, output logic [9:0] fr);
    while (lineIn !== 1'b0) @(posedge clk);
    repeat (bp / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      fr[i] = lineIn;
      repeat (bp) @(posedge clk);
    end
  endtask : catchAsync
  // slave side: drive on fall, sample on rise, lsb first
  task automatic syncSlave(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      @(negedge sclkIn) lineOut <= tx[i];
      @(posedge sclkIn) rx[i] = lineIn;
    end
    // hold time over, so the old bit is not left standing
    lineOut <= ~tx[7];
  endtask : syncSlave
  // master side for slave tests: fall and drive, sample on rise
  task automatic syncMaster(input int hp, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sclkOut <= 1'b0;
      lineOut <= tx[i];
      repeat (hp) @(posedge clk);
      sclkOut <= 1'b1;
      rx[i] = lineIn;
      repeat (hp - 1) @(posedge clk);
    end
  endtask : syncMaster
endmodule : dsp_term_model
`default_nettype wire

//--- dual_mode_serial_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dual_mode_serial_port_bench;
  logic                 clk     = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 tick    = 1'b0;
  logic                 rxLine;
  logic                 sclk;
  logic                 txIrq;
  logic                 rxIrq;
  logic                 slvClk;
  int                   rxIrqs   = 0;
  int                   errors   = 0;
  int                   compares = 0;
  int                   cycles   = 0;
  int                   irqs     = 0;
  logic [31:0]          q;
  logic [9:0]           f;
  logic [7:0]           r;
  dsp_pkg::dsp_wb_req_t wbReq = '0;
  dsp_pkg::dsp_wb_rsp_t wbRsp;
  dsp_pkg::dsp_pins_t   pinOut;

  always #50 clk = ~clk;
  // one oscillator and timer pulse every other cycle
  always @(posedge clk) tick <= ~tick;
  // pulled-up clock pin
  assign sclk = pinOut.serialClockOe ? pinOut.serialClockOut : 1'b1;

  dsp_serial_port DUT (.clk(clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp), .fastOscTick(tick),
    .timerUnderflow(tick), .serialDataIn(rxLine), .serialClockIn(slvClk), .pinOut(pinOut),
    .txCompleteIrq(txIrq), .rxCompleteIrq(rxIrq));
  dsp_term_model peer (.clk(clk), .lineIn(pinOut.serialDataOut), .sclkIn(sclk), .sclkOut(slvClk),
    .lineOut(rxLine));

  task automatic test_done;
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    irqs += int'(txIrq === 1'b1);
    rxIrqs += int'(rxIrq === 1'b1);
    if (cycles == 90000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) wbReq <= '{1'b1, 1'b1, we, 4'hf, a, d};
    do @(posedge clk); while (wbRsp.ack !== 1'b1);
    q = wbRsp.dat;
    wbReq <= '0;
  endtask : wb

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wb(0, 8'h00, 0); chk("ctrl", 32'h0, q);
    wb(0, 8'h0c, 0); chk("unmapped", 32'h0, q);
    // async8, timer source, both enables, tx irq on: 64 cycles a bit
    wb(1, 8'h00, 32'h1cf);
    wb(1, 8'h08, 32'ha5);
    wb(1, 8'h04, 32'h1);
    wb(0, 8'h04, 0); chk("txbusy", 32'h1, q & 32'h1);
    fork
      peer.catchAsync(64, f);
      peer.sendAsync(64, 8'h3c);
    join
    chk("txframe", {22'h0, 1'b1, 8'ha5, 1'b0}, 32'(f));
    repeat (100) @(posedge clk);
    chk("irq", 32'h1, 32'(irqs));
    wb(0, 8'h04, 0); chk("status", 32'h20, q);
    wb(0, 8'h08, 0); chk("rxdata", 32'h3c, q);
    peer.sendAsync(64, 8'h81);
    repeat (20) @(posedge clk);
    wb(0, 8'h04, 0); chk("overrun", 32'h24, q);
    wb(0, 8'h08, 0); chk("rxdata2", 32'h81, q);
    wb(1, 8'h04, 32'h6);
    peer.sendAsync(64, 8'h7e);
    repeat (20) @(posedge clk);
    wb(0, 8'h04, 0); chk("nooverrun", 32'h20, q);
    // divide-by-93 source: 93 * 2 * 16 cycles a bit
    wb(1, 8'h00, 32'h4b);
    wb(1, 8'h08, 32'h33);
    wb(1, 8'h04, 32'h1);
    peer.catchAsync(2976, f);
    chk("div93", {22'h0, 1'b1, 8'h33, 1'b0}, 32'(f));
    repeat (3000) @(posedge clk);
    // sync master: enables cleared first, then tx only
    wb(1, 8'h00, 32'h0c);
    wb(1, 8'h00, 32'h4c);
    wb(1, 8'h08, 32'h96);
    wb(1, 8'h04, 32'h1);
    chk("sclkoe", 32'h1, {31'h0, pinOut.serialClockOe});
    peer.syncSlave(8'h00, r);
    chk("synctx", 32'h96, 32'(r));
    repeat (20) @(posedge clk);
    wb(1, 8'h00, 32'h0c);
    wb(1, 8'h00, 32'h8c);
    wb(1, 8'h04, 32'h2);
    peer.syncSlave(8'h5a, r);
    repeat (20) @(posedge clk);
    wb(0, 8'h08, 0); chk("syncrx", 32'h5a, q);
    // sync slave: peer drives the clock, 20 cycles a half period
    wb(1, 8'h00, 32'h01);
    wb(1, 8'h00, 32'h41);
    wb(1, 8'h08, 32'hc3);
    wb(1, 8'h04, 32'h1);
    chk("ready", 32'h2, {30'h0, pinOut.slaveReadyOe, pinOut.slaveReadyOutputN});
    peer.syncMaster(20, 8'h00, r);
    chk("slavetx", 32'hc3, 32'(r));
    repeat (20) @(posedge clk);
    wb(1, 8'h00, 32'h01);
    wb(1, 8'h00, 32'h281);
    wb(1, 8'h04, 32'h2);
    peer.syncMaster(20, 8'h69, r);
    repeat (20) @(posedge clk);
    wb(0, 8'h08, 0); chk("slaverx", 32'h69, q);
    chk("rxirq", 32'h1, 32'(rxIrqs));
    test_done();
  end
endmodule : dual_mode_serial_port_bench
`default_nettype wire
